// ### core/rx_tone_core.sv
// receive gain decode, pcm receive deserializer and tone/buzzer generator
// assumes register writes arrive decoded from the control interface, and a
// pcm controller clocks PCM_DIN/PCM_FRAME_SYNC on its own PCM_CLK

// Contract
// - receive gain code 0 gives +6 dB, 1 dB less per step to -6 dB
// - receive gain resets to code 1010, that is -4 dB
// - in tone mode the receive gain code picks 12, 6, 0, -6 or -12
// - sidetone code 0 gives -12 dB, 2 dB less per step to -26 dB
// - power control bit 7 mutes sidetone regardless of its gain
// - sidetone gain resets to code 000, -12 dB
// - earphone volume code 0 gives 0 dB, 2 dB less per step to -30
// - earphone volume resets to code 0000, 0 dB
// - power control bit 3 mutes the earphone
// - companded words are 8 bits, msb first
// - linear words are 15 bits msb first, slot 16 unused
// - two 8-bit tone registers, high at 04 and low at 05
// - high tone is 2 dB louder than low tone
// - auxiliary bits 2 to 5 choose the tone resolution
// - finest resolution reaches 1992.2 Hz, coarser ones two and four times
// - tones reach RX_LINEAR in tone mode and the buzzer when its enable and tone mode are both set; RX_CODE always carries pcm data
// - low tone peak 31, placed into receive word as 3968
// - high tone peak 39, placed into receive word as 4992
// - summed tone peak 70, receive word peak 8960
// - buzzer carries a pulse density stream of the selected tone
// - linear words are two's complement, companded are mu or A law
module rx_tone_core
	import rx_tone_pkg::*;
(
	// system
	input  wire logic              CLK,
	input  wire logic              RSTN,
	// register port from the control interface
	input  wire logic              REG_WE,
	input  wire logic [2:0]        REG_ADDR,
	input  wire logic [7:0]        REG_WDATA,
	output      logic [7:0]        REG_RDATA,
	// pcm receive link
	input  wire logic              PCM_CLK,
	input  wire logic              PCM_FRAME_SYNC,
	input  wire logic              PCM_DIN,
	// receive channel word
	output      logic              RX_STROBE,
	output      logic [14:0]       RX_LINEAR,
	output      logic [7:0]        RX_CODE,
	output      logic              RX_COMPANDED,
	output      logic              RX_ALAW,
	output      logic              EAR_ENABLE,
	// decoded gains
	output      logic signed [4:0] RX_GAIN_DB,
	output      logic              RX_GAIN_DEFINED,
	output      logic signed [4:0] TONE_GAIN_DB,
	output      logic signed [5:0] SIDE_GAIN_DB,
	output      logic              SIDE_MUTE,
	output      logic signed [5:0] EAR_VOL_DB,
	output      logic              EAR_MUTE,
	// tone
	output      logic signed [7:0] TONE_SAMPLE,
	output      logic              BUZZER_PULSE_DENSITY_OUT
);

	// programmed registers
	logic [7:0]  power_ctl;
	logic [7:0]  mode_ctl;
	logic [7:0]  txpga;
	logic [7:0]  rxpga;
	logic [7:0]  high_tone_frequency;
	logic [7:0]  low_tone_frequency;
	logic [7:0]  auxiliary_control;
	// copies applied at the frame boundary
	logic [7:0]  act_power;
	logic [7:0]  act_mode;
	logic [2:0]  act_side;
	logic [7:0]  act_rxpga;
	logic [7:0]  act_high;
	logic [7:0]  act_low;
	logic [7:0]  act_aux;
	// pcm domain
	logic [3:0]  slot;
	logic [13:0] shifter;
	logic [14:0] pcm_hold;
	logic        word_tog;
	// clock domain crossing
	logic [2:0]  tog_sync;
	logic        tog_seen;
	logic        frame_tick;
	// tone
	logic [9:0]  phase_high;
	logic [9:0]  phase_low;
	logic [9:0]  next_phase_high;
	logic [9:0]  next_phase_low;
	logic signed [7:0] high_val;
	logic signed [7:0] low_val;
	logic signed [7:0] next_sum;
	logic [8:0]  pdm_acc;

	// quarter-wave table, peak 39 for high tone and 31 for low tone
	function automatic logic signed [7:0] tone_lookup(input logic [9:0] ph, input logic hi);
		logic [2:0] idx;
		logic [7:0] mag;
		idx = ph[8] ? ~ph[7:5] : ph[7:5];
		unique case (idx)
			3'h0: mag = hi ? 8'h04 : 8'h03;
			3'h1: mag = hi ? 8'h0b : 8'h09;
			3'h2: mag = hi ? 8'h12 : 8'h0f;
			3'h3: mag = hi ? 8'h19 : 8'h14;
			3'h4: mag = hi ? 8'h1e : 8'h18;
			3'h5: mag = hi ? 8'h22 : 8'h1b;
			3'h6: mag = hi ? 8'h25 : 8'h1e;
			3'h7: mag = hi ? 8'h27 : 8'h1f;
		endcase
		tone_lookup = ph[9] ? -$signed(mag) : $signed(mag);
	endfunction

	// register writes; reset values give -4 dB rx gain, -12 dB sidetone, 0 dB volume
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			power_ctl           <= POWER_RST;
			mode_ctl            <= MODE_RST;
			txpga               <= TXPGA_RST;
			rxpga               <= RXPGA_RST;
			high_tone_frequency <= HIGH_RST;
			low_tone_frequency  <= LOW_RST;
			auxiliary_control   <= AUX_RST;
		end else if (REG_WE) begin
			unique case (REG_ADDR)
				ADDR_POWER: power_ctl <= REG_WDATA;
				ADDR_MODE:  mode_ctl  <= REG_WDATA;
				ADDR_TXPGA: txpga     <= REG_WDATA;
				ADDR_RXPGA: rxpga     <= REG_WDATA;
				ADDR_HIGH:  high_tone_frequency <= REG_WDATA;
				ADDR_LOW:   low_tone_frequency  <= REG_WDATA;
				ADDR_AUX:   auxiliary_control   <= REG_WDATA;
				default: ; // unmapped offset ignored
			endcase
		end
	end

	// read back one cycle after the address is presented; unmapped reads zero
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RDATA <= 8'h00;
		end else begin
			unique case (REG_ADDR)
				ADDR_POWER: REG_RDATA <= power_ctl;
				ADDR_MODE:  REG_RDATA <= mode_ctl;
				ADDR_TXPGA: REG_RDATA <= txpga;
				ADDR_RXPGA: REG_RDATA <= rxpga;
				ADDR_HIGH:  REG_RDATA <= high_tone_frequency;
				ADDR_LOW:   REG_RDATA <= low_tone_frequency;
				ADDR_AUX:   REG_RDATA <= auxiliary_control;
				default:    REG_RDATA <= 8'h00;
			endcase
		end
	end

	// pcm slot counter and shifter; frame sync marks slot 1, msb first
	always_ff @(posedge PCM_CLK or negedge RSTN) begin
		if (!RSTN) begin
			slot    <= 4'h0;
			shifter <= 14'h0000;
		end else if (PCM_FRAME_SYNC) begin
			slot    <= 4'h1;
			shifter <= {13'h0000, PCM_DIN};
		end else if (slot != 4'h0 && slot <= PCM_LAST_SLOT) begin
			slot    <= slot + 4'h1;
			shifter <= {shifter[12:0], PCM_DIN};
		end else begin
			slot    <= 4'h0; // slot 16 and idle time carry no data
		end
	end

	// word complete after slot 15; held a whole frame so the other side reads it calmly
	always_ff @(posedge PCM_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pcm_hold <= 15'h0000;
			word_tog <= 1'b0;
		end else if (!PCM_FRAME_SYNC && slot == PCM_LAST_SLOT) begin
			pcm_hold <= {shifter, PCM_DIN};
			word_tog <= ~word_tog;
		end
	end

	// toggle crossing: three flops, event once the second and third agree
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tog_sync <= 3'h0;
			tog_seen <= 1'b0;
		end else begin
			tog_sync <= {tog_sync[1:0], word_tog};
			if (frame_tick)
				tog_seen <= tog_sync[2];
		end
	end
	assign frame_tick = (tog_sync[1] == tog_sync[2]) && (tog_sync[2] != tog_seen);

	// settings move to the working copies only at the frame boundary
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			act_power <= POWER_RST;
			act_mode  <= MODE_RST;
			act_side  <= TXPGA_RST[2:0];
			act_rxpga <= RXPGA_RST;
			act_high  <= HIGH_RST;
			act_low   <= LOW_RST;
			act_aux   <= AUX_RST;
		end else if (frame_tick) begin
			act_power <= power_ctl;
			act_mode  <= mode_ctl;
			act_side  <= txpga[2:0];
			act_rxpga <= rxpga;
			act_high  <= high_tone_frequency;
			act_low   <= low_tone_frequency;
			act_aux   <= auxiliary_control;
		end
	end

	// gain decode, registered so every output leaves a flop
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			RX_GAIN_DB      <= 5'sh00;
			RX_GAIN_DEFINED <= 1'b0;
			TONE_GAIN_DB    <= 5'sh00;
			SIDE_GAIN_DB    <= 6'sh00;
			SIDE_MUTE       <= 1'b1;
			EAR_VOL_DB      <= 6'sh00;
			EAR_MUTE        <= 1'b0;
		end else begin
			RX_GAIN_DB <= RX_GAIN_TOP - $signed({1'b0, act_rxpga[7:4]});
			RX_GAIN_DEFINED <= act_rxpga[7:4] <= RX_GAIN_LAST;
			unique case (act_rxpga[7:4])
				4'h0, 4'h1, 4'h2: TONE_GAIN_DB <= TONE_P12;
				4'h3, 4'h4, 4'h5: TONE_GAIN_DB <= TONE_P6;
				4'h6, 4'h7, 4'h8: TONE_GAIN_DB <= TONE_0;
				4'h9, 4'ha, 4'hb: TONE_GAIN_DB <= TONE_M6;
				default:          TONE_GAIN_DB <= TONE_M12;
			endcase
			SIDE_GAIN_DB <= SIDE_TOP - $signed({2'b00, act_side, 1'b0});
			SIDE_MUTE    <= act_power[SIDE_MUTE_BIT];
			EAR_VOL_DB   <= VOL_TOP - $signed({1'b0, act_rxpga[3:0], 1'b0});
			EAR_MUTE     <= act_power[EAR_MUTE_BIT];
		end
	end

	// phase steps: resolution code 00, 01, else scales the step by 1, 2 or 4
	always_comb begin
		unique case (act_aux[HIGH_RES_LSB +: 2])
			2'h0:    next_phase_high = phase_high + {2'b00, act_high};
			2'h1:    next_phase_high = phase_high + {1'b0, act_high, 1'b0};
			default: next_phase_high = phase_high + {act_high, 2'b00};
		endcase
		unique case (act_aux[LOW_RES_LSB +: 2])
			2'h0:    next_phase_low = phase_low + {2'b00, act_low};
			2'h1:    next_phase_low = phase_low + {1'b0, act_low, 1'b0};
			default: next_phase_low = phase_low + {act_low, 2'b00};
		endcase
	end

	// a zero frequency register silences its generator rather than holding a dc level
	assign high_val = (act_high == 8'h00) ? 8'sh00 : tone_lookup(phase_high, 1'b1);
	assign low_val  = (act_low == 8'h00) ? 8'sh00 : tone_lookup(phase_low, 1'b0);
	assign next_sum = high_val + low_val;

	// generators advance once per frame, i.e. at the 8 kHz sample rate
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			phase_high  <= 10'h000;
			phase_low   <= 10'h000;
			TONE_SAMPLE <= 8'sh00;
		end else if (!act_mode[TONE_MODE_BIT]) begin
			phase_high  <= 10'h000;
			phase_low   <= 10'h000;
			TONE_SAMPLE <= 8'sh00;
		end else if (frame_tick) begin
			phase_high  <= next_phase_high;
			phase_low   <= next_phase_low;
			TONE_SAMPLE <= next_sum;
		end
	end

	// receive channel word: tone replaces pcm data in RX_LINEAR in tone mode; RX_CODE keeps pcm data
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			RX_STROBE    <= 1'b0;
			RX_LINEAR    <= 15'h0000;
			RX_CODE      <= 8'h00;
			RX_COMPANDED <= 1'b0;
			RX_ALAW      <= 1'b0;
			EAR_ENABLE   <= 1'b0;
		end else begin
			RX_STROBE    <= frame_tick;
			RX_COMPANDED <= act_mode[COMP_EN_BIT];
			RX_ALAW      <= act_mode[ALAW_BIT];
			EAR_ENABLE   <= !act_power[RX_OFF_BIT] && !act_power[EAR_MUTE_BIT];
			if (frame_tick) begin
				RX_CODE <= pcm_hold[14:7];
				if (act_mode[TONE_MODE_BIT])
					RX_LINEAR <= {TONE_SAMPLE, 7'h00};
				else
					RX_LINEAR <= pcm_hold;
			end
		end
	end

	// first-order pulse density modulator; gated by the buzzer enable and tone mode together
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pdm_acc                  <= 9'h000;
			BUZZER_PULSE_DENSITY_OUT <= 1'b0;
		end else if (act_mode[BUZZ_EN_BIT] && act_mode[TONE_MODE_BIT]) begin
			pdm_acc <= {1'b0, pdm_acc[7:0]} + {1'b0, RX_LINEAR[14:7] ^ PDM_OFFSET};
			BUZZER_PULSE_DENSITY_OUT <= pdm_acc[8];
		end else begin
			pdm_acc                  <= 9'h000;
			BUZZER_PULSE_DENSITY_OUT <= 1'b0;
		end
	end

	// checks; decoded outputs trail the frame tick by two edges
	sequence s_frame_apply;
		frame_tick ##2 1'b1;
	endsequence

	a_rx_gain_decode: assert property (@(posedge CLK) disable iff (!RSTN)
		frame_tick && rxpga[7:4] <= RX_GAIN_LAST |-> ##2
		RX_GAIN_DB == 5'sh06 - $signed({1'b0, $past(rxpga[7:4], 2)}))
		else $error("rx gain decode wrong");
	a_rx_gain_reset: assert property (@(posedge CLK) disable iff (!RSTN)
		frame_tick && rxpga == RXPGA_RST |-> ##2 RX_GAIN_DB == 5'sh1c)
		else $error("rx gain reset value wrong");
	a_tone_gain_top: assert property (@(posedge CLK) disable iff (!RSTN)
		(rxpga[7:4] <= 4'h2) ##0 s_frame_apply |-> TONE_GAIN_DB == 5'sh0c)
		else $error("tone gain decode wrong");
	a_side_gain_step: assert property (@(posedge CLK) disable iff (!RSTN)
		s_frame_apply |-> SIDE_GAIN_DB == 6'sh34 - $signed({2'b00, $past(txpga[2:0], 2), 1'b0}))
		else $error("sidetone gain decode wrong");
	a_side_mute_follow: assert property (@(posedge CLK) disable iff (!RSTN)
		frame_tick |-> ##2 SIDE_MUTE == $past(power_ctl[SIDE_MUTE_BIT], 2))
		else $error("sidetone mute not applied");
	a_ear_volume_step: assert property (@(posedge CLK) disable iff (!RSTN)
		frame_tick |-> ##2 EAR_VOL_DB == 6'sh00 - $signed({1'b0, $past(rxpga[3:0], 2), 1'b0}))
		else $error("earphone volume decode wrong");
	a_ear_mute_gate: assert property (@(posedge CLK) disable iff (!RSTN)
		frame_tick && power_ctl[EAR_MUTE_BIT] |-> ##2 EAR_MUTE && !EAR_ENABLE)
		else $error("earphone not muted");
	a_pcm_word_msb: assert property (@(posedge PCM_CLK) disable iff (!RSTN)
		PCM_FRAME_SYNC ##1 (!PCM_FRAME_SYNC)[*8] ##0 slot == 4'h8 |->
		##7 pcm_hold[14] == $past(PCM_DIN, 15))
		else $error("pcm msb not first");
	a_settings_hold: assert property (@(posedge CLK) disable iff (!RSTN)
		!frame_tick |=> $stable(act_rxpga) && $stable(act_power) && $stable(act_high))
		else $error("setting applied inside a frame");
	a_tone_peaks: assert property (@(posedge CLK) disable iff (!RSTN)
		high_val <= HIGH_PEAK && -high_val <= HIGH_PEAK &&
		low_val <= LOW_PEAK && -low_val <= LOW_PEAK &&
		next_sum <= SUM_PEAK && -next_sum <= SUM_PEAK)
		else $error("tone exceeds peak");
	a_high_louder: assert property (@(posedge CLK) disable iff (!RSTN)
		phase_high == phase_low && act_high != 8'h00 && act_low != 8'h00 && !phase_high[9]
		|-> high_val > low_val)
		else $error("high tone not louder");
	a_buzzer_gated: assert property (@(posedge CLK) disable iff (!RSTN)
		!act_mode[BUZZ_EN_BIT] ##1 !act_mode[BUZZ_EN_BIT] |-> !BUZZER_PULSE_DENSITY_OUT)
		else $error("buzzer active while disabled");
endmodule

// ### core/rx_tone_pkg.sv
// constants for the receive gain decode and tone generator block
// assumes an 8-bit register port fed by the control interface decoder
package rx_tone_pkg;

	// register offsets
	localparam logic [2:0] ADDR_POWER = 3'h0;
	localparam logic [2:0] ADDR_MODE  = 3'h1;
	localparam logic [2:0] ADDR_TXPGA = 3'h2;
	localparam logic [2:0] ADDR_RXPGA = 3'h3;
	localparam logic [2:0] ADDR_HIGH  = 3'h4;
	localparam logic [2:0] ADDR_LOW   = 3'h5;
	localparam logic [2:0] ADDR_AUX   = 3'h6;

	// reset values
	localparam logic [7:0] POWER_RST = 8'hf6;
	localparam logic [7:0] MODE_RST  = 8'h02;
	localparam logic [7:0] TXPGA_RST = 8'h40;
	localparam logic [7:0] RXPGA_RST = 8'ha0;
	localparam logic [7:0] HIGH_RST  = 8'h00;
	localparam logic [7:0] LOW_RST   = 8'h00;
	localparam logic [7:0] AUX_RST   = 8'h00;

	// field positions
	localparam int SIDE_MUTE_BIT = 7;
	localparam int EAR_MUTE_BIT  = 3;
	localparam int RX_OFF_BIT    = 2;
	localparam int ALAW_BIT      = 7;
	localparam int TONE_MODE_BIT = 6;
	localparam int COMP_EN_BIT   = 4;
	localparam int BUZZ_EN_BIT   = 3;
	localparam int RX_GAIN_LSB   = 4;
	localparam int HIGH_RES_LSB  = 4;
	localparam int LOW_RES_LSB   = 2;

	// gain decode figures
	localparam logic [3:0]        RX_GAIN_LAST = 4'hc;
	localparam logic signed [4:0] RX_GAIN_TOP  = 5'sh06;
	localparam logic signed [5:0] SIDE_TOP     = 6'sh34;
	localparam logic signed [5:0] VOL_TOP      = 6'sh00;
	localparam logic signed [4:0] TONE_P12     = 5'sh0c;
	localparam logic signed [4:0] TONE_P6      = 5'sh06;
	localparam logic signed [4:0] TONE_0       = 5'sh00;
	localparam logic signed [4:0] TONE_M6      = 5'sh1a;
	localparam logic signed [4:0] TONE_M12     = 5'sh14;

	// pcm word framing: last slot index of the 15-bit capture
	localparam logic [3:0] PCM_LAST_SLOT = 4'he;
	localparam int         TONE_SHIFT    = 7;
	localparam logic [7:0] PDM_OFFSET    = 8'h80;

	// tone peaks
	localparam logic signed [7:0] LOW_PEAK  = 8'sh1f;
	localparam logic signed [7:0] HIGH_PEAK = 8'sh27;
	localparam logic signed [7:0] SUM_PEAK  = 8'sh46;

endpackage

// ### testbench/pcm_link_model.sv
// pcm controller model: frame sync and msb-first serial words on its own link clock
// assumes the receiver samples frame sync and data on the rising link clock edge
module pcm_link_model (
	// link pins
	output logic PCM_CLK,
	output logic PCM_FRAME_SYNC,
	output logic PCM_DIN
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle link at time zero
	initial begin
		PCM_CLK = 1'b0;
		PCM_FRAME_SYNC = 1'b0;
		PCM_DIN = 1'b0;
	end

	// bare clock pulses, so the link side sees edges while reset is held
	task automatic pulses(input int n);
		repeat (n) begin
			#80 PCM_CLK = 1'b1;
			#80 PCM_CLK = 1'b0;
		end
	endtask

	// one 16-slot frame, 160 ns per slot; the clock stands still between frames.
	// frames follow each other far faster than 8 kHz to keep the run short
	task automatic send(input logic [14:0] word);
		#3;
		for (int slot = 0; slot < 16; slot++) begin
			PCM_FRAME_SYNC = (slot == 0);
			PCM_DIN = (slot < 15) ? word[14 - slot] : ~word[0];
			#80 PCM_CLK = 1'b1;
			#80 PCM_CLK = 1'b0;
		end
		// released line shows the inverse of the last slot, never a stale bit
		PCM_FRAME_SYNC = 1'b0;
		PCM_DIN = word[0];
	endtask
endmodule

// ### testbench/test_rx_tone_core.sv
// self-checking bench: register port tasks, pcm frames and tone peak checks
// assumes the pcm model drives the link clock only inside frames, apart from one pulse during reset
module test_rx_tone_core
	import rx_tone_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 60000;

	logic              CLK = 1'b0;
	logic              RSTN;
	logic              REG_WE;
	logic [2:0]        REG_ADDR;
	logic [7:0]        REG_WDATA;
	logic [7:0]        REG_RDATA;
	logic              PCM_CLK;
	logic              PCM_FRAME_SYNC;
	logic              PCM_DIN;
	logic              RX_STROBE;
	logic [14:0]       RX_LINEAR;
	logic [7:0]        RX_CODE;
	logic              RX_COMPANDED;
	logic              RX_ALAW;
	logic              EAR_ENABLE;
	logic signed [4:0] RX_GAIN_DB;
	logic              RX_GAIN_DEFINED;
	logic signed [4:0] TONE_GAIN_DB;
	logic signed [5:0] SIDE_GAIN_DB;
	logic              SIDE_MUTE;
	logic signed [5:0] EAR_VOL_DB;
	logic              EAR_MUTE;
	logic signed [7:0] TONE_SAMPLE;
	logic              BUZZER_PULSE_DENSITY_OUT;
	int                num_errors = 0;
	int                checked = 0;
	int                cycles = 0;
	int                strobes = 0;
	int                buzz_ones = 0;
	logic [7:0]        rst_val [8] = '{POWER_RST, MODE_RST, TXPGA_RST, RXPGA_RST,
		HIGH_RST, LOW_RST, AUX_RST, 8'h00};
	logic [7:0]        pw [3] = '{8'h72, 8'h7a, 8'hf6};
	logic [14:0]       words [3] = '{15'h4001, 15'h2aaa, 15'h7ffe};

	rx_tone_core rx_tone_core_i (.CLK(CLK), .RSTN(RSTN), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PCM_CLK(PCM_CLK),
		.PCM_FRAME_SYNC(PCM_FRAME_SYNC), .PCM_DIN(PCM_DIN), .RX_STROBE(RX_STROBE),
		.RX_LINEAR(RX_LINEAR), .RX_CODE(RX_CODE), .RX_COMPANDED(RX_COMPANDED),
		.RX_ALAW(RX_ALAW), .EAR_ENABLE(EAR_ENABLE), .RX_GAIN_DB(RX_GAIN_DB),
		.RX_GAIN_DEFINED(RX_GAIN_DEFINED), .TONE_GAIN_DB(TONE_GAIN_DB),
		.SIDE_GAIN_DB(SIDE_GAIN_DB), .SIDE_MUTE(SIDE_MUTE), .EAR_VOL_DB(EAR_VOL_DB),
		.EAR_MUTE(EAR_MUTE), .TONE_SAMPLE(TONE_SAMPLE),
		.BUZZER_PULSE_DENSITY_OUT(BUZZER_PULSE_DENSITY_OUT));

	pcm_link_model pcm_link_model_i (.PCM_CLK(PCM_CLK), .PCM_FRAME_SYNC(PCM_FRAME_SYNC),
		.PCM_DIN(PCM_DIN));

	// 125 MHz system clock
	always #4 CLK = ~CLK;

	task automatic end_of_test();
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// cycle ceiling, strobe and buzzer counters
	always @(posedge CLK) begin
		cycles++;
		if (RX_STROBE === 1'b1)
			strobes++;
		buzz_ones += int'(BUZZER_PULSE_DENSITY_OUT === 1'b1);
		if (cycles == LIMIT) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
		checked++;
		if (seen !== expv) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, expv, seen);
		end
	endtask

	// one write: strobe high for exactly one edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_WE <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK);
		REG_WE <= 1'b0;
	endtask

	// read data is registered, so look one edge after the address settles
	task automatic rd(input logic [2:0] a, input logic [7:0] expv);
		@(posedge CLK);
		REG_ADDR <= a;
		@(posedge CLK);
		@(negedge CLK);
		check("read data", 16'(REG_RDATA), 16'(expv));
	endtask

	// send a frame, then wait a bounded time for its single strobe
	task automatic frame(input logic [14:0] w);
		int s0;
		int n;
		s0 = strobes;
		pcm_link_model_i.send(w);
		n = 0;
		while (strobes == s0 && n < 40) begin
			@(posedge CLK);
			n++;
		end
		repeat (4) @(posedge CLK);
		@(negedge CLK);
		check("strobes per frame", 16'(strobes - s0), 16'h0001);
	endtask

	// tone register values are frequency over resolution, higher tone in the high register
	task automatic tone_case(input logic [7:0] aux, input logic [7:0] hi, input logic [7:0] lo,
		input int peak);
		int mx;
		int lx;
		int b0;
		int c0;
		wr(ADDR_AUX, aux);
		wr(ADDR_HIGH, hi);
		wr(ADDR_LOW, lo);
		wr(ADDR_MODE, 8'h4a);
		mx = 0;
		lx = 0;
		b0 = buzz_ones;
		c0 = cycles;
		repeat (9) begin
			frame(15'h0000);
			if (TONE_SAMPLE > mx)
				mx = TONE_SAMPLE;
			if ($signed(RX_LINEAR) > lx)
				lx = $signed(RX_LINEAR);
		end
		check("tone peak", 16'(mx), 16'(peak));
		check("rx word peak", 16'(lx), 16'(peak * 128));
		check("buzzer mix", 16'(buzz_ones > b0 && buzz_ones - b0 < cycles - c0), 16'h1);
		rd(ADDR_AUX, aux);
		rd(ADDR_HIGH, hi);
		rd(ADDR_LOW, lo);
		// tone mode off zeroes the phases, so the next case starts in step
		wr(ADDR_MODE, MODE_RST);
		frame(15'h0000);
	endtask

	initial begin
		int b0;
		RSTN = 1'b0;
		REG_WE = 1'b0;
		REG_ADDR = 3'h0;
		REG_WDATA = 8'h00;
		fork
			pcm_link_model_i.pulses(1);
		join_none
		repeat (20) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		check("reset rx gain", 16'(RX_GAIN_DB), 16'(-4));
		check("reset side gain", 16'(SIDE_GAIN_DB), 16'(-12));
		check("reset volume", 16'(EAR_VOL_DB), 16'h0000);
		check("reset side mute", 16'(SIDE_MUTE), 16'h0001);
		for (int a = 0; a < 8; a++)
			rd(3'(a), rst_val[a]);
		wr(3'h7, 8'hff);
		rd(3'h7, 8'h00);
		// receive gain codes 0 to 14, with sidetone and volume codes riding along
		for (int c = 0; c < 15; c++) begin
			wr(ADDR_TXPGA, 8'(8'h40 | (c % 7)));
			wr(ADDR_RXPGA, 8'((c << 4) | (c % 10)));
			if (c == 0) begin
				repeat (8) @(posedge CLK);
				@(negedge CLK);
				check("held gain", 16'(RX_GAIN_DB), 16'(-4));
			end
			frame(15'h0000);
			if (c <= 12)
				check("rx gain", 16'(RX_GAIN_DB), 16'(6 - c));
			check("gain defined", 16'(RX_GAIN_DEFINED), 16'(c <= 12));
			check("tone gain", 16'(TONE_GAIN_DB), 16'(12 - 6 * (c / 3)));
			check("side gain", 16'(SIDE_GAIN_DB), 16'(-12 - 2 * (c % 7)));
			check("ear volume", 16'(EAR_VOL_DB), 16'(-2 * (c % 10)));
		end
		// mutes and the earphone enable follow the power bits alone
		foreach (pw[i]) begin
			wr(ADDR_POWER, pw[i]);
			frame(15'h0000);
			check("side mute", 16'(SIDE_MUTE), 16'(pw[i][7]));
			check("side gain kept", 16'(SIDE_GAIN_DB), 16'(-12));
			check("ear mute", 16'(EAR_MUTE), 16'(pw[i][3]));
			check("ear enable", 16'(EAR_ENABLE), 16'(!pw[i][2] && !pw[i][3]));
		end
		foreach (words[i]) begin
			frame(words[i]);
			check("linear word", 16'(RX_LINEAR), 16'(words[i]));
			check("code byte", 16'(RX_CODE), 16'(words[i][14:7]));
		end
		wr(ADDR_MODE, 8'h92);
		frame(15'h5b00);
		check("companded byte", 16'(RX_CODE), 16'h00b6);
		check("companded flag", 16'(RX_COMPANDED), 16'h0001);
		check("a-law flag", 16'(RX_ALAW), 16'h0001);
		wr(ADDR_MODE, MODE_RST);
		frame(15'h0000);
		tone_case(8'h00, 8'h00, 8'h40, 31);
		tone_case(8'h04, 8'h00, 8'h80, 31);
		tone_case(8'h08, 8'h00, 8'h40, 31);
		tone_case(8'h20, 8'h40, 8'h00, 39);
		tone_case(8'h28, 8'h40, 8'h40, 70);
		b0 = buzz_ones;
		frame(15'h0000);
		check("buzzer idle", 16'(buzz_ones - b0), 16'h0000);
		end_of_test();
	end
endmodule
